/* File: shared/config_port_defines.svh */
// Constants for the configuration host ports: addressing, fill bytes,
// bit counts. Included by the design file only.
`ifndef CONFIG_PORT_DEFINES_SVH
`define CONFIG_PORT_DEFINES_SVH

// First five bits of a 10-bit two-wire address
`define CP_TEN_PREFIX   5'h1E
// Sub-address targets, low two address bits
`define CP_SUB_CFG      2'h0
`define CP_SUB_USER_PRI 2'h1
`define CP_SUB_USER_SEC 2'h2
`define CP_SUB_RESET    2'h3
// Returned when no response byte is queued
`define CP_IDLE_BYTE    8'hFF
// Opcode of a direct configuration SRAM access, refused on serial port
`define CP_SRAM_OPCODE  8'hA5
// Index of the last bit of a byte
`define CP_LAST_BIT     3'h7

`endif

/* File: shared/config_port_pkg.sv */
// Types for the configuration host ports.
// Assumes the defines header is compiled alongside.
package config_port_pkg;

    typedef enum logic [2:0] {
        TW_IDLE,
        TW_ADDR,
        TW_ADDR2,
        TW_WRITE,
        TW_ACK,
        TW_READ,
        TW_MACK,
        TW_SKIP
    } twi_state_t;

    typedef struct packed {
        logic       selS1;
        logic       selS2;
        logic       togS1;
        logic       togS2;
        logic       togS3;
        logic       sclS1;
        logic       sclS2;
        logic       sclS3;
        logic       sdaS1;
        logic       sdaS2;
        logic       sdaS3;
        logic       linkRst;
        logic       serialEn;
        logic       twoWireEn;
        logic       dropFrame;
        logic [7:0] txHold;
        logic [7:0] cmdData;
        logic       cmdValid;
        logic       cmdFromTwoWire;
        logic       cmdFirst;
        logic       respReady;
        logic       interpReset;
        logic       reloadPend;
        logic       reloadStart;
        logic       sramRefused;
        twi_state_t twState;
        twi_state_t twAfter;
        logic [2:0] twCnt;
        logic [7:0] twShift;
        logic [1:0] twSub;
        logic       twRead;
        logic       twAckPend;
        logic       twTenHit;
        logic [1:0] twTenSub;
        logic       sdaOe;
    } sys_state_t;

    typedef struct packed {
        logic [2:0] bitCnt;
        logic [6:0] rxShift;
        logic [7:0] rxByte;
        logic       rxFirst;
        logic       firstPend;
        logic [7:0] txShift;
    } ser_state_t;

endpackage : config_port_pkg

/* File: src/config_logic_host_ports.sv */
// Host-facing ports of the configuration logic: a mode-0 serial slave
// clocked by the external master and a two-wire slave with sub-address
// decode. Assumes the interpreter sits on clk_sys and that the
// open-drain lines and serial output are resolved outside.
//
// Overview of operation
// R1 - Serial port samples input bits on each rising serial clock edge.
// R2 - Serial output bits change on falling edges so they are valid at rising edges.
// R3 - Select high deselects the serial port and floats its output.
// R4 - Transfers are accepted only while select is held low.
// R5 - Only clock-polarity-zero, clock-phase-zero serial transfers.
// R6 - Image reload waits until the serial select has been released.
// R7 - Serial port reaches flash and option row, never configuration SRAM.
// R8 - Serial port is active while the option row is at default.
// R9 - Two-wire port accepts both 7-bit and 10-bit addressing.
// R10 - Two-wire bus clock runs at 400 kHz at most.
// R11 - Default addresses are 1000000 (7-bit) and 1111000000 (10-bit).
// R12 - Low two address bits pick target; 00 and 11 answer, but reads of 11 are refused.
// R13 - Both two-wire controllers share one base; only primary reaches config.
// R14 - Abandoned transactions leave queued response data in place.
// R15 - Any write to sub-address 3 resets interpreter and flushes responses.
// R16 - Surrounding logic supplies bus clock at least 7.5x two-wire rate.
// R17 - Secondary two-wire controller never reaches the configuration logic.
// R18 - Two-wire port active in erased option-row state or when kept.
// R19 - On-chip bus accesses only in user mode with transparent operations.
`timescale 1ns/1ps
`include "config_port_defines.svh"

module config_logic_host_ports (
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic       configSerialClock,
    input  wire logic       portSelectN,
    input  wire logic       serialDataIn,
    output logic            serialDataOut,
    output logic            serialDataOe,
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    input  wire logic       optionRowDefault,
    input  wire logic       optionRowErased,
    input  wire logic       serialKeep,
    input  wire logic       twoWireKeep,
    input  wire logic [4:0] addrBase7,
    input  wire logic [7:0] addrBase10,
    input  wire logic [7:0] respData,
    input  wire logic       respValid,
    input  wire logic       reloadCmd,
    output logic [7:0]      cmdData,
    output logic            cmdValid,
    output logic            cmdFromTwoWire,
    output logic            cmdFirst,
    output logic            respReady,
    output logic            interpReset,
    output logic            reloadStart,
    output logic            sramRefused,
    output logic            serialEnabled,
    output logic            twoWireEnabled
);

    config_port_pkg::sys_state_t r;
    config_port_pkg::sys_state_t n;
    config_port_pkg::ser_state_t s;
    config_port_pkg::ser_state_t sn;
    logic                        rxToggle;
    logic                        sdoReg;
    logic                        twStart;
    logic                        twStop;
    logic                        sclRise;
    logic                        sclFall;

    function automatic logic [7:0] respByte(input logic v,
                                            input logic [7:0] d);
        return v ? d : `CP_IDLE_BYTE;
    endfunction : respByte

    function automatic logic cfgTarget(input logic [1:0] sub);
        return (sub == `CP_SUB_CFG) || (sub == `CP_SUB_RESET);
    endfunction : cfgTarget

    // Serial link domain; select high clears the frame state
    always_comb begin
        sn = s;
        sn.rxShift = {s.rxShift[5:0], serialDataIn};             // [R1]
        sn.bitCnt = s.bitCnt + 3'h1;
        sn.txShift = {s.txShift[6:0], 1'b1};
        if (s.bitCnt == `CP_LAST_BIT) begin
            sn.rxByte = {s.rxShift, serialDataIn};               // [R1]
            sn.rxFirst = s.firstPend;
            sn.firstPend = 1'b0;
            sn.txShift = r.txHold;
        end
    end

    always_ff @(posedge configSerialClock or posedge portSelectN) begin
        if (portSelectN) begin                                   // [R4]
            // Last byte and its first flag stay for the system side
            s.bitCnt <= 3'h0;
            s.rxShift <= 7'h00;
            s.firstPend <= 1'b1;
            s.txShift <= `CP_IDLE_BYTE;
        end else begin
            s <= sn;
        end
    end

    // Byte event toggle; survives select so no event is lost
    always_ff @(posedge configSerialClock or posedge r.linkRst) begin
        if (r.linkRst) begin
            rxToggle <= 1'b0;
        end else if (!portSelectN && s.bitCnt == `CP_LAST_BIT) begin
            rxToggle <= ~rxToggle;
        end
    end

    // Output changes on falling edge, mode 0 only
    always_ff @(negedge configSerialClock or posedge portSelectN) begin
        if (portSelectN) begin
            sdoReg <= 1'b1;
        end else begin
            sdoReg <= s.txShift[7];                              // [R2] [R5]
        end
    end

    assign twStart = r.sclS2 & r.sclS3 & r.sdaS3 & ~r.sdaS2;
    assign twStop  = r.sclS2 & r.sclS3 & ~r.sdaS3 & r.sdaS2;
    assign sclRise = r.sclS2 & ~r.sclS3;
    assign sclFall = ~r.sclS2 & r.sclS3;

    always_comb begin
        logic       serialPop;
        logic       hit;
        logic       twLoadNow;
        logic [7:0] b;
        logic [7:0] twLoad;
        serialPop = 1'b0;
        hit = 1'b0;
        twLoadNow = 1'b0;
        twLoad = `CP_IDLE_BYTE;
        b = {r.twShift[6:0], r.sdaS2};
        n = r;
        n.selS1 = portSelectN;
        n.selS2 = r.selS1;
        n.togS1 = rxToggle;
        n.togS2 = r.togS1;
        n.togS3 = r.togS2;
        n.sclS1 = sclIn;                                         // [R10]
        n.sclS2 = r.sclS1;
        n.sclS3 = r.sclS2;
        n.sdaS1 = sdaIn;
        n.sdaS2 = r.sdaS1;
        n.sdaS3 = r.sdaS2;
        n.linkRst = 1'b0;
        n.serialEn = optionRowDefault | serialKeep;               // [R8]
        n.twoWireEn = optionRowErased | twoWireKeep;              // [R18]
        n.cmdValid = 1'b0;
        n.respReady = 1'b0;
        n.interpReset = 1'b0;
        n.reloadStart = 1'b0;
        n.sramRefused = 1'b0;

        // Serial byte arrived; word is stable for a whole byte time
        if (r.togS2 != r.togS3 && r.serialEn) begin              // [R8]
            if (s.rxFirst) begin
                n.dropFrame = (s.rxByte == `CP_SRAM_OPCODE);     // [R7]
                n.sramRefused = n.dropFrame;                     // [R7]
            end
            if (!n.dropFrame) begin
                n.cmdValid = 1'b1;
                n.cmdData = s.rxByte;
                n.cmdFromTwoWire = 1'b0;
                n.cmdFirst = s.rxFirst;
            end
            serialPop = 1'b1;
            n.txHold = respByte(respValid, respData);
            n.respReady = respValid;
        end

        // Reload waits for deselect; a new request beats the launch
        if (reloadCmd) begin
            n.reloadPend = 1'b1;
        end else if (r.reloadPend && r.selS2) begin               // [R6]
            n.reloadPend = 1'b0;
            n.reloadStart = 1'b1;
        end

        twLoad = respByte(respValid && !serialPop, respData);

        if (!n.twoWireEn) begin                                  // [R18]
            n.twState = config_port_pkg::TW_IDLE;
            n.sdaOe = 1'b0;
            n.twAckPend = 1'b0;
        end else if (twStart) begin
            n.twState = config_port_pkg::TW_ADDR;
            n.twCnt = 3'h0;
            n.sdaOe = 1'b0;
            n.twAckPend = 1'b0;
        end else if (twStop) begin
            // Queued response deliberately kept across stop
            n.twState = config_port_pkg::TW_IDLE;                // [R14]
            n.sdaOe = 1'b0;
            n.twAckPend = 1'b0;
            n.twTenHit = 1'b0;
        end else if (r.twAckPend && sclFall) begin
            n.twAckPend = 1'b0;
            n.sdaOe = 1'b1;
            n.twState = config_port_pkg::TW_ACK;
        end else begin
            unique case (r.twState)
                config_port_pkg::TW_IDLE,
                config_port_pkg::TW_SKIP: begin
                end
                config_port_pkg::TW_ADDR,
                config_port_pkg::TW_ADDR2,
                config_port_pkg::TW_WRITE: begin
                    if (sclRise && !r.twAckPend) begin
                        n.twShift = b;
                        n.twCnt = r.twCnt + 3'h1;
                        if (r.twCnt == `CP_LAST_BIT) begin
                            if (r.twState == config_port_pkg::TW_WRITE) begin
                                hit = 1'b1;
                                n.twAfter = config_port_pkg::TW_WRITE;
                                if (r.twSub == `CP_SUB_RESET) begin
                                    n.interpReset = 1'b1;        // [R15]
                                end else if (!serialPop) begin
                                    n.cmdValid = 1'b1;
                                    n.cmdData = b;
                                    n.cmdFromTwoWire = 1'b1;
                                    n.cmdFirst = 1'b0;
                                end
                            end else if (r.twState == config_port_pkg::TW_ADDR2)
                            begin
                                if (b[7:2] == addrBase10[5:0] &&
                                    cfgTarget(b[1:0])) begin     // [R12]
                                    hit = 1'b1;
                                    n.twTenHit = 1'b1;
                                    n.twTenSub = b[1:0];
                                    n.twSub = b[1:0];
                                    n.twAfter = config_port_pkg::TW_WRITE;
                                end
                            end else if (b[7:3] == `CP_TEN_PREFIX) begin
                                if (b[2:1] == addrBase10[7:6]) begin  // [R9]
                                    if (!b[0]) begin
                                        hit = 1'b1;
                                        n.twAfter = config_port_pkg::TW_ADDR2;
                                    end else if (r.twTenHit &&
                                        r.twTenSub == `CP_SUB_CFG) begin
                                        hit = 1'b1;
                                        n.twAfter = config_port_pkg::TW_READ;
                                    end
                                end
                            end else if (b[7:3] == addrBase7 &&
                                         cfgTarget(b[2:1]) &&     // [R11]
                                         !(b[0] &&
                                         b[2:1] == `CP_SUB_RESET)) begin
                                // User-mode targets belong elsewhere
                                hit = 1'b1;                      // [R13] [R17]
                                n.twSub = b[2:1];
                                n.twAfter = b[0] ? config_port_pkg::TW_READ
                                                 : config_port_pkg::TW_WRITE;
                            end
                            n.twAckPend = hit;
                            if (!hit) begin
                                n.twState = config_port_pkg::TW_SKIP;
                            end
                        end
                    end
                end
                config_port_pkg::TW_ACK: begin
                    if (sclFall) begin
                        n.sdaOe = 1'b0;
                        n.twCnt = 3'h0;
                        n.twState = r.twAfter;
                        twLoadNow = (r.twAfter == config_port_pkg::TW_READ);
                    end
                end
                config_port_pkg::TW_READ: begin
                    if (sclFall) begin
                        n.twCnt = r.twCnt + 3'h1;
                        if (r.twCnt == `CP_LAST_BIT) begin
                            n.sdaOe = 1'b0;
                            n.twRead = 1'b0;
                            n.twState = config_port_pkg::TW_MACK;
                        end else begin
                            n.twShift = {r.twShift[6:0], 1'b1};
                            n.sdaOe = ~r.twShift[6];
                        end
                    end
                end
                config_port_pkg::TW_MACK: begin
                    if (sclRise) begin
                        n.twRead = ~r.sdaS2;
                    end else if (sclFall) begin
                        n.twCnt = 3'h0;
                        twLoadNow = r.twRead;
                        n.twState = r.twRead ? config_port_pkg::TW_READ
                                             : config_port_pkg::TW_SKIP;
                    end
                end
            endcase
        end

        if (twLoadNow) begin
            n.twShift = twLoad;
            n.sdaOe = ~twLoad[7];
            n.respReady = respValid && !serialPop;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            r <= '0;
            r.linkRst <= 1'b1;
            r.txHold <= `CP_IDLE_BYTE;
        end else begin
            r <= n;
        end
    end

    assign serialDataOut  = sdoReg;
    assign serialDataOe   = ~portSelectN & r.serialEn;           // [R3]
    assign sdaOut         = 1'b0;
    assign sdaOe          = r.sdaOe;
    assign cmdData        = r.cmdData;
    assign cmdValid       = r.cmdValid;
    assign cmdFromTwoWire = r.cmdFromTwoWire;
    assign cmdFirst       = r.cmdFirst;
    assign respReady      = r.respReady;
    assign interpReset    = r.interpReset;
    assign reloadStart    = r.reloadStart;
    assign sramRefused    = r.sramRefused;
    assign serialEnabled  = r.serialEn;
    assign twoWireEnabled = r.twoWireEn;

    a_rx_sample: assert property (                               // [R1]
        @(posedge configSerialClock) disable iff (portSelectN)
        s.bitCnt == `CP_LAST_BIT |=>
            s.rxByte == {$past(s.rxShift), $past(serialDataIn)})
        else $error("serial byte not taken on rising edges");

    a_out_falling: assert property (                             // [R2]
        @(negedge configSerialClock) disable iff (portSelectN)
        1'b1 |=> sdoReg == $past(s.txShift[7]))
        else $error("serial output not updated on falling edge");

    a_deselect_float: assert property (                          // [R3]
        @(posedge clk_sys) disable iff (srst)
        portSelectN |-> !serialDataOe)
        else $error("serial output driven while deselected");

    a_cmd_single: assert property (                              // [R4]
        @(posedge clk_sys) disable iff (srst)
        cmdValid && !cmdFromTwoWire |=> !cmdValid)
        else $error("serial byte delivered twice");

    a_reload_defer: assert property (                            // [R6]
        @(posedge clk_sys) disable iff (srst)
        reloadStart |-> $past(r.selS2) && !$past(reloadCmd))
        else $error("reload launched while selected");

    a_sram_refuse: assert property (                             // [R7]
        @(posedge clk_sys) disable iff (srst)
        sramRefused |-> !cmdValid ##1 !(cmdValid && cmdFirst))
        else $error("SRAM opcode passed to interpreter");

    a_serial_gate: assert property (                             // [R8]
        @(posedge clk_sys) disable iff (srst)
        cmdValid && !cmdFromTwoWire |-> $past(r.serialEn))
        else $error("serial byte accepted while port disabled");

    a_ack_on_low: assert property (                              // [R9]
        @(posedge clk_sys) disable iff (srst)
        $rose(sdaOe) |-> $past(sclFall))
        else $error("data line driven outside clock low phase");

    a_reset_flush: assert property (                             // [R15]
        @(posedge clk_sys) disable iff (srst)
        interpReset |-> !cmdValid && r.twSub == `CP_SUB_RESET)
        else $error("interpreter reset from wrong target");

    a_cfg_only: assert property (                                // [R17]
        @(posedge clk_sys) disable iff (srst)
        cmdValid && cmdFromTwoWire |-> r.twSub == `CP_SUB_CFG)
        else $error("non-config target reached interpreter");

    a_twi_gate: assert property (                                // [R18]
        @(posedge clk_sys) disable iff (srst)
        sdaOe |-> twoWireEnabled)
        else $error("two-wire line driven while port disabled");

endmodule : config_logic_host_ports

/* File: tb/host_master_model.sv */
// Serial mode-0 master and two-wire master for the host ports.
// Assumes the bench calls one task at a time.
// No on-chip bus master here, so no offline access can deadlock
`timescale 1ns/1ps
module host_master_model (
    output logic      configSerialClock,
    output logic      portSelectN,
    output logic      serialDataIn,
    input  wire logic serialDataOut,
    input  wire logic serialDataOe,
    output logic      sclIn,
    output wire logic sdaIn,
    input  wire logic sdaOe
);
    localparam real HALF = 15.0;
    localparam real QTR  = 625.0;
    logic sdaLow;
    // Open-drain line with pull-up
    assign sdaIn = ~(sdaLow | sdaOe);
    initial begin
        configSerialClock = 1'b0;
        portSelectN = 1'b1;
        serialDataIn = 1'b0;
        sclIn = 1'b1;
        sdaLow = 1'b0;
    end
    // Transfers only inside a low select
    task automatic spi_select(input logic low);
        portSelectN = ~low;
        #(2 * HALF);
        if (!low) serialDataIn = ~serialDataIn;
    endtask : spi_select
    // Clock idles low, data set before the rise
    task automatic spi_byte(input logic [7:0] d, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            serialDataIn = d[i];
            #HALF configSerialClock = 1'b1;
            // Floating line reads as the inverse of the last bit
            r[i] = serialDataOe ? serialDataOut : ~serialDataOut;
            #HALF configSerialClock = 1'b0;
        end
    endtask : spi_byte
    task automatic tw_start();
        sdaLow = 1'b0;
        #QTR sclIn = 1'b1;
        #QTR sdaLow = 1'b1;
        #QTR sclIn = 1'b0;
        #QTR;
    endtask : tw_start
    task automatic tw_stop();
        sdaLow = 1'b1;
        #QTR sclIn = 1'b1;
        #QTR sdaLow = 1'b0;
        #QTR;
    endtask : tw_stop
    // Four quarters a bit: 400 kHz
    task automatic tw_byte(input logic [7:0] d, output logic [7:0] r,
                           output logic ack);
        for (int i = 8; i >= 0; i--) begin
            sdaLow = (i > 0) ? ~d[(i + 7) % 8] : 1'b0;
            #QTR sclIn = 1'b1;
            #QTR;
            if (i > 0) r[(i + 7) % 8] = sdaIn;
            else ack = ~sdaIn;
            #QTR sclIn = 1'b0;
            #QTR;
        end
    endtask : tw_byte
endmodule : host_master_model

/* File: tb/tb.sv */
// Self-checking bench for the configuration host ports.
// Assumes the master model drives the serial and two-wire pins.
`timescale 1ns/1ps
module tb;
    logic       clk_sys = 1'b0;
    logic       srst, optionRowDefault, serialKeep, optionRowErased;
    logic       twoWireKeep, respValid, reloadCmd;
    logic [7:0] respData;
    logic       configSerialClock, portSelectN, serialDataIn, sclIn, sdaIn;
    logic       serialDataOut, serialDataOe, sdaOe, cmdValid, cmdFirst;
    logic       cmdFromTwoWire, respReady, interpReset, reloadStart;
    logic       sramRefused, serialEnabled, twoWireEnabled, lastTw, ack;
    logic [7:0] cmdData, lastCmd, q;
    int         miscompares = 0;
    int         comparisons = 0;
    int         nCmd = 0, nFirst = 0, nRef = 0, nRst = 0, nRel = 0, nResp = 0;
    // Enable inputs beside expected enables
    logic [5:0] rows [6] = '{6'h00, 6'h22, 6'h12, 6'h09, 6'h05, 6'h3F};
    always #20 clk_sys = ~clk_sys; // 25 MHz, above 7.5x two-wire
    config_logic_host_ports u_dut (.clk_sys(clk_sys), .srst(srst),
        .configSerialClock(configSerialClock), .portSelectN(portSelectN),
        .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
        .serialDataOe(serialDataOe), .sclIn(sclIn), .sdaIn(sdaIn),
        .sdaOut(), .sdaOe(sdaOe), .optionRowDefault(optionRowDefault),
        .optionRowErased(optionRowErased), .serialKeep(serialKeep),
        .twoWireKeep(twoWireKeep), .addrBase7(5'h10), .addrBase10(8'hF0),
        .respData(respData), .respValid(respValid), .reloadCmd(reloadCmd),
        .cmdData(cmdData), .cmdValid(cmdValid),
        .cmdFromTwoWire(cmdFromTwoWire), .cmdFirst(cmdFirst),
        .respReady(respReady), .interpReset(interpReset),
        .reloadStart(reloadStart), .sramRefused(sramRefused),
        .serialEnabled(serialEnabled), .twoWireEnabled(twoWireEnabled));
    host_master_model u_host (.configSerialClock(configSerialClock),
        .portSelectN(portSelectN), .serialDataIn(serialDataIn),
        .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
        .sclIn(sclIn), .sdaIn(sdaIn), .sdaOe(sdaOe));
    always @(posedge clk_sys) begin
        if (cmdValid === 1'b1) begin
            nCmd++;
            lastCmd = cmdData;
            lastTw = cmdFromTwoWire;
        end
        if (cmdValid === 1'b1 && cmdFirst === 1'b1) nFirst++;
        if (sramRefused === 1'b1) nRef++;
        if (interpReset === 1'b1) nRst++;
        if (reloadStart === 1'b1) nRel++;
        if (respReady === 1'b1) nResp++;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc
    task automatic tw_addr(input logic [7:0] a, input logic [7:0] d,
                           input logic exp);
        u_host.tw_start();
        u_host.tw_byte(a, q, ack);
        check({7'h0, ack}, {7'h0, exp});
        if (exp) u_host.tw_byte(d, q, ack);
        u_host.tw_stop();
        cyc(4);
    endtask : tw_addr
    task automatic final_report();
        if (miscompares == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report
    initial begin
        cyc(40000);
        miscompares++;
        final_report();
    end
    initial begin
        srst <= 1'b1;
        {optionRowDefault, serialKeep, optionRowErased, twoWireKeep} <= 4'h0;
        {respValid, reloadCmd} <= 2'h0;
        respData <= 8'hFF;
        cyc(4);
        check({6'h0, serialEnabled, twoWireEnabled}, 8'h00);
        srst <= 1'b0;
        foreach (rows[i]) begin
            @(posedge clk_sys);
            {optionRowDefault, serialKeep, optionRowErased, twoWireKeep}
                <= rows[i][5:2];
            cyc(3);
            check({6'h0, serialEnabled, twoWireEnabled},
                  {6'h0, rows[i][1:0]});
        end
        check({7'h0, serialDataOe}, 8'h00);
        u_host.spi_select(1'b1);
        check({7'h0, serialDataOe}, 8'h01);
        u_host.spi_byte(8'h3C, q);
        check(q, 8'hFF);
        u_host.spi_byte(8'h5B, q);
        u_host.spi_select(1'b0);
        cyc(8);
        check(8'(nCmd), 8'h02);
        check(8'(nFirst), 8'h01);
        check(lastCmd, 8'h5B);
        check({7'h0, lastTw}, 8'h00);
        u_host.spi_select(1'b1);
        u_host.spi_byte(8'hA5, q);
        u_host.spi_byte(8'h11, q);
        u_host.spi_select(1'b0);
        cyc(8);
        check(8'(nRef), 8'h01);
        check(8'(nCmd), 8'h02);
        u_host.spi_select(1'b1);
        @(posedge clk_sys);
        reloadCmd <= 1'b1;
        @(posedge clk_sys);
        reloadCmd <= 1'b0;
        cyc(8);
        check(8'(nRel), 8'h00);
        u_host.spi_select(1'b0);
        cyc(8);
        check(8'(nRel), 8'h01);
        @(posedge clk_sys);
        {optionRowDefault, serialKeep} <= 2'h0;
        cyc(3);
        u_host.spi_select(1'b1);
        check({7'h0, serialDataOe}, 8'h00);
        u_host.spi_byte(8'h42, q);
        check(q, 8'h00);
        u_host.spi_select(1'b0);
        cyc(8);
        check(8'(nCmd), 8'h02);
        tw_addr(8'h82, 8'h00, 1'b0);
        tw_addr(8'h84, 8'h00, 1'b0);
        tw_addr(8'h87, 8'h00, 1'b0);
        tw_addr(8'h86, 8'h77, 1'b1);
        check(8'(nRst), 8'h01);
        tw_addr(8'h80, 8'hC3, 1'b1);
        check(lastCmd, 8'hC3);
        check({7'h0, lastTw}, 8'h01);
        u_host.tw_start();
        u_host.tw_byte(8'hF6, q, ack);
        u_host.tw_byte(8'hC0, q, ack);
        check({7'h0, ack}, 8'h01);
        u_host.tw_byte(8'h96, q, ack);
        u_host.tw_stop();
        cyc(4);
        check(lastCmd, 8'h96);
        @(posedge clk_sys);
        respData <= 8'h5A;
        respValid <= 1'b1;
        u_host.tw_start();
        u_host.tw_byte(8'h81, q, ack);
        u_host.tw_byte(8'hFF, q, ack);
        @(posedge clk_sys);
        respValid <= 1'b0;
        u_host.tw_stop();
        check(q, 8'h5A);
        check({7'h0, nResp > 0}, 8'h01);
        final_report();
    end
endmodule : tb
